// ==== design/scrmm_consts.vh ====
`ifndef SCRMM_CONSTS_VH
`define SCRMM_CONSTS_VH
// ----------------------------------------
// register space layout
// ----------------------------------------
`define SCRMM_SCRATCH_TOP 8'h7f
`define SCRMM_SPECIAL_BASE 8'h80
`define SCRMM_BIT_BYTE_BASE 8'h20
`define SCRMM_BANK_TOP 8'h1f
// ----------------------------------------
// special register offsets
// ----------------------------------------
`define SCRMM_OFS_SP 8'h81
`define SCRMM_OFS_PSW 8'hd0
`define SCRMM_OFS_MAPCTL 8'hc6
`define SCRMM_OFS_RANGECTL 8'hd8
// ----------------------------------------
// reset values
// ----------------------------------------
`define SCRMM_SP_RST 8'h07
`define SCRMM_PSW_RST 8'h00
`define SCRMM_MAPCTL_RST 8'h00
`define SCRMM_RANGECTL_RST 8'h00
// ----------------------------------------
// field positions
// ----------------------------------------
`define SCRMM_PSW_BANK_HI 4
`define SCRMM_PSW_BANK_LO 3
`define SCRMM_MAP_PART_HI 7
`define SCRMM_MAP_PART_LO 4
`define SCRMM_MAP_RANGE 3
`define SCRMM_RNG_SIZE_HI 2
`define SCRMM_RNG_SIZE_LO 0
`define SCRMM_RNG_EXT 7
`endif

// ==== design/scrmm_route.v ====
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// memory routing decode
// ----------------------------------------
module scrmm_route (
  input wire fetch_in,
  input wire [15:0] addr_in,
  input wire [3:0] part_in,
  input wire range_big_in,
  input wire ext_variant_in,
  input wire [2:0] size_sel_in,
  output wire to_byte_out,
  output wire [16:0] limit_out
);
  wire [16:0] part_addr;
  wire [16:0] range_lim;
  wire [16:0] ext_lim;
  // partition in 2kB steps, last step 4kB
  assign part_addr = (part_in == 4'hf) ? 17'h08000 : {2'b00, part_in, 11'h000};
  // basic: 8kB or 32kB; extended: 8kB shl size, clamped to 64kB address space
  assign ext_lim = (size_sel_in > 3'h3) ? 17'h10000 : (17'h02000 << size_sel_in);
  assign range_lim = ext_variant_in ? ext_lim : (range_big_in ? 17'h08000 : 17'h02000);
  assign limit_out = range_lim;
  // program below partition, data from partition up to range
  assign to_byte_out = fetch_in ? ({1'b0, addr_in} < part_addr && {1'b0, addr_in} < range_lim)
                                : ({1'b0, addr_in} >= part_addr && {1'b0, addr_in} < range_lim);
endmodule // scrmm_route
`default_nettype wire

// ==== design/scrmm_top.v ====
`include "scrmm_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module scrmm_top (
  input wire ref_clk_in,
  input wire sys_rst_in,
  input wire ext_variant_in,
  input wire main_power_ok_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire reg_indirect_in,
  input wire reg_bit_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire wr_bank_reg_in,
  input wire rd_bank_reg_in,
  input wire [2:0] bank_index_in,
  input wire push_in,
  input wire pop_in,
  input wire [7:0] push_data_in,
  input wire mem_req_in,
  input wire mem_fetch_in,
  input wire mem_wr_in,
  input wire [15:0] mem_addr_in,
  input wire [7:0] mem_wdata_in,
  input wire [7:0] byte_rdata_in,
  input wire [7:0] exp_rdata_in,
  output reg [7:0] reg_rdata_out,
  output reg [7:0] pop_data_out,
  output reg [7:0] stack_pointer_out,
  output reg [7:0] mem_rdata_out,
  output reg [16:0] byte_addr_out,
  output reg [7:0] byte_wdata_out,
  output reg byte_rw_n_out,
  output reg byte_ce0_n_out,
  output reg byte_ce1_n_out,
  output reg byte_supply_on_out,
  output reg exp_req_out,
  output reg exp_wr_out,
  output reg exp_fetch_out,
  output reg [15:0] exp_addr_out,
  output reg [7:0] exp_wdata_out,
  output reg wr_blocked_out
);
  // ----------------------------------------
  // storage and registers
  // ----------------------------------------
  reg [7:0] scratch_mem [0:127];
  reg [7:0] stack_pointer_ff;
  reg [7:0] program_status_word_ff;
  reg [7:0] memory_map_control_ff;
  reg [7:0] partition_range_control_ff;
  reg size_locked_ff;
  reg [7:0] nxt_sp;
  reg [7:0] nxt_rdata;
  reg [6:0] bank_addr;
  reg [6:0] bit_byte;
  reg [7:0] bit_byte_val;
  wire to_byte;
  wire [16:0] range_lim;
  wire is_special;
  wire direct_wr;
  wire [7:0] byte_val_rd;
  wire data_wr_in_prog;
  // ----------------------------------------
  // address classification
  // ----------------------------------------
  assign is_special = reg_addr_in[7];
  // indirect writes to special space have no effect
  assign direct_wr = reg_wr_in & ~(is_special & reg_indirect_in);
  assign byte_val_rd = scratch_mem[reg_addr_in[6:0]];
  always @* begin
    // working register within 00h-1Fh
    bank_addr = {2'b00, program_status_word_ff[`SCRMM_PSW_BANK_HI:`SCRMM_PSW_BANK_LO],
                 bank_index_in};
    // bit address: byte 20h + bit[6:3]
    bit_byte = {3'b010, reg_addr_in[6:3]};
    bit_byte_val = scratch_mem[bit_byte];
  end
  // ----------------------------------------
  // read data
  // ----------------------------------------
  always @* begin
    nxt_rdata = 8'h00;
    if (rd_bank_reg_in) begin
      nxt_rdata = scratch_mem[bank_addr];
    end else if (reg_bit_in) begin
      nxt_rdata = {7'h00, bit_byte_val[reg_addr_in[2:0]]};
    end else if (!is_special) begin
      nxt_rdata = byte_val_rd;
    end else if (reg_indirect_in) begin
      nxt_rdata = 8'h00;
    end else begin
      case (reg_addr_in)
        `SCRMM_OFS_SP: nxt_rdata = stack_pointer_ff;
        `SCRMM_OFS_PSW: nxt_rdata = program_status_word_ff;
        `SCRMM_OFS_MAPCTL: nxt_rdata = memory_map_control_ff;
        `SCRMM_OFS_RANGECTL: nxt_rdata = ext_variant_in ? partition_range_control_ff : 8'h00;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end
  // ----------------------------------------
  // stack pointer
  // ----------------------------------------
  always @* begin
    nxt_sp = stack_pointer_ff;
    if (push_in) begin
      nxt_sp = stack_pointer_ff + 8'h01;
    end else if (pop_in) begin
      nxt_sp = stack_pointer_ff - 8'h01;
    end else if (direct_wr && !reg_bit_in && reg_addr_in == `SCRMM_OFS_SP) begin
      nxt_sp = reg_wdata_in;
    end
  end
  // ----------------------------------------
  // scratchpad, no reset so contents survive
  // ----------------------------------------
  always @(posedge ref_clk_in) begin
    if (push_in) begin
      scratch_mem[nxt_sp[6:0]] <= push_data_in;
    end else if (wr_bank_reg_in) begin
      scratch_mem[bank_addr] <= reg_wdata_in;
    end else if (direct_wr && reg_bit_in && !is_special) begin
      scratch_mem[bit_byte] <= (bit_byte_val & ~(8'h01 << reg_addr_in[2:0]))
                               | ({7'h00, reg_wdata_in[0]} << reg_addr_in[2:0]);
    end else if (reg_wr_in && !is_special && !reg_bit_in) begin
      scratch_mem[reg_addr_in[6:0]] <= reg_wdata_in;
    end
  end
  // ----------------------------------------
  // special registers
  // ----------------------------------------
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      stack_pointer_ff <= `SCRMM_SP_RST;
      program_status_word_ff <= `SCRMM_PSW_RST;
      stack_pointer_out <= `SCRMM_SP_RST;
      pop_data_out <= 8'h00;
      reg_rdata_out <= 8'h00;
    end else begin
      stack_pointer_ff <= nxt_sp;
      stack_pointer_out <= nxt_sp;
      if (pop_in && !push_in) begin
        pop_data_out <= scratch_mem[stack_pointer_ff[6:0]];
      end
      reg_rdata_out <= nxt_rdata;
      if (direct_wr && !reg_bit_in && reg_addr_in == `SCRMM_OFS_PSW) begin
        program_status_word_ff <= reg_wdata_in;
      end
    end
  end
  // map control kept nonvolatile: no reset
  always @(posedge ref_clk_in) begin
    if (direct_wr && !reg_bit_in && reg_addr_in == `SCRMM_OFS_MAPCTL) begin
      // partition changeable at run time; range bit only before lock
      memory_map_control_ff[`SCRMM_MAP_PART_HI:`SCRMM_MAP_PART_LO] <=
        reg_wdata_in[`SCRMM_MAP_PART_HI:`SCRMM_MAP_PART_LO];
      memory_map_control_ff[2:0] <= reg_wdata_in[2:0];
      if (!size_locked_ff) begin
        memory_map_control_ff[`SCRMM_MAP_RANGE] <= reg_wdata_in[`SCRMM_MAP_RANGE];
      end
    end
    if (direct_wr && !reg_bit_in && ext_variant_in && !size_locked_ff
        && reg_addr_in == `SCRMM_OFS_RANGECTL) begin
      partition_range_control_ff <= reg_wdata_in;
    end
  end
  // size setting locks after the first direct write to the map control register
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      size_locked_ff <= 1'b0;
    end else if (reg_wr_in && reg_addr_in == `SCRMM_OFS_MAPCTL && !reg_indirect_in) begin
      size_locked_ff <= 1'b1;
    end
  end
  // ----------------------------------------
  // memory routing
  // ----------------------------------------
  scrmm_route u_route (
    .fetch_in(mem_fetch_in),
    .addr_in(mem_addr_in),
    .part_in(memory_map_control_ff[`SCRMM_MAP_PART_HI:`SCRMM_MAP_PART_LO]),
    .range_big_in(memory_map_control_ff[`SCRMM_MAP_RANGE]),
    .ext_variant_in(ext_variant_in),
    .size_sel_in(partition_range_control_ff[`SCRMM_RNG_SIZE_HI:`SCRMM_RNG_SIZE_LO]),
    .to_byte_out(to_byte),
    .limit_out(range_lim)
  );
  // write into program address on bytewide bus is refused
  assign data_wr_in_prog = mem_wr_in && !mem_fetch_in && !to_byte
                           && ({1'b0, mem_addr_in} < range_lim)
                           && (mem_addr_in < ((memory_map_control_ff[7:4] == 4'hf) ? 16'h8000
                               : {1'b0, memory_map_control_ff[7:4], 11'h000}));
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      byte_addr_out <= 17'h00000;
      byte_wdata_out <= 8'h00;
      byte_rw_n_out <= 1'b1;
      byte_ce0_n_out <= 1'b1;
      byte_ce1_n_out <= 1'b1;
      byte_supply_on_out <= 1'b0;
      exp_req_out <= 1'b0;
      exp_wr_out <= 1'b0;
      exp_fetch_out <= 1'b0;
      exp_addr_out <= 16'h0000;
      exp_wdata_out <= 8'h00;
      wr_blocked_out <= 1'b0;
      mem_rdata_out <= 8'h00;
    end else begin
      byte_supply_on_out <= main_power_ok_in;
      byte_ce0_n_out <= 1'b1;
      byte_ce1_n_out <= 1'b1;
      byte_rw_n_out <= 1'b1;
      exp_req_out <= 1'b0;
      exp_wr_out <= 1'b0;
      wr_blocked_out <= mem_req_in && data_wr_in_prog;
      mem_rdata_out <= to_byte ? byte_rdata_in : exp_rdata_in;
      if (mem_req_in && to_byte && !data_wr_in_prog) begin
        byte_addr_out <= {1'b0, mem_addr_in};
        byte_wdata_out <= mem_wdata_in;
        byte_rw_n_out <= ~(mem_wr_in && !mem_fetch_in);
        byte_ce0_n_out <= mem_addr_in[15];
        byte_ce1_n_out <= ~mem_addr_in[15];
      end else if (mem_req_in && !data_wr_in_prog) begin
        exp_req_out <= 1'b1;
        exp_fetch_out <= mem_fetch_in;
        exp_wr_out <= mem_wr_in && !mem_fetch_in;
        exp_addr_out <= mem_addr_in;
        exp_wdata_out <= mem_wdata_in;
      end
    end
  end
endmodule // scrmm_top
`default_nettype wire

// ==== tb/scrmm_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----
// checks on the top module ports
// ----
module scrmm_checker (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic main_power_ok_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic reg_indirect_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic push_in,
  input wire logic pop_in,
  input wire logic mem_req_in,
  input wire logic mem_fetch_in,
  input wire logic mem_wr_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [7:0] stack_pointer_out,
  input wire logic byte_rw_n_out,
  input wire logic byte_ce0_n_out,
  input wire logic byte_ce1_n_out,
  input wire logic byte_supply_on_out,
  input wire logic exp_req_out,
  input wire logic wr_blocked_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  property p_sp_rst;
    $past(sys_rst_in) |-> stack_pointer_out == 8'h07;
  endproperty
  a_sp_rst: assert property (p_sp_rst) else $error("sp after reset");
  property p_push;
    push_in && !reg_wr_in |=> stack_pointer_out == $past(stack_pointer_out) + 8'h01;
  endproperty
  a_push: assert property (p_push) else $error("push pointer");
  property p_pop;
    pop_in && !push_in && !reg_wr_in |=> stack_pointer_out == $past(stack_pointer_out) - 8'h01;
  endproperty
  a_pop: assert property (p_pop) else $error("pop pointer");
  property p_hold;
    !push_in && !pop_in && !reg_wr_in |=> $stable(stack_pointer_out);
  endproperty
  a_hold: assert property (p_hold) else $error("pointer moved");
  property p_ind;
    reg_rd_in && reg_indirect_in && reg_addr_in[7] |=> reg_rdata_out == 8'h00;
  endproperty
  a_ind: assert property (p_ind) else $error("indirect read");
  property p_blk;
    wr_blocked_out |-> byte_ce0_n_out && byte_ce1_n_out && !exp_req_out;
  endproperty
  a_blk: assert property (p_blk) else $error("blocked write moved");
  property p_fetch;
    mem_req_in && mem_fetch_in && !mem_wr_in |=> byte_rw_n_out && !wr_blocked_out;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch wrote");
  property p_route;
    mem_req_in |=> !byte_ce0_n_out || !byte_ce1_n_out || exp_req_out || wr_blocked_out;
  endproperty
  a_route: assert property (p_route) else $error("request lost");
  property p_idle;
    !mem_req_in |=> byte_ce0_n_out && byte_ce1_n_out && !exp_req_out;
  endproperty
  a_idle: assert property (p_idle) else $error("bus not idle");
  property p_sup;
    !$past(sys_rst_in) |-> byte_supply_on_out == $past(main_power_ok_in);
  endproperty
  a_sup: assert property (p_sup) else $error("supply");
endmodule // scrmm_checker
bind scrmm_top scrmm_checker chk_u (.ref_clk_in, .sys_rst_in, .main_power_ok_in, .reg_wr_in,
  .reg_rd_in, .reg_indirect_in, .reg_addr_in, .push_in, .pop_in, .mem_req_in, .mem_fetch_in,
  .mem_wr_in, .reg_rdata_out, .stack_pointer_out, .byte_rw_n_out, .byte_ce0_n_out,
  .byte_ce1_n_out, .byte_supply_on_out, .exp_req_out, .wr_blocked_out);
`default_nettype wire

// ==== tb/scrmm_mem_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----
// bytewide ram and expanded bus responder
// ----
module scrmm_mem_model (
  input wire logic ref_clk_in,
  input wire logic [16:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic rw_n_in,
  input wire logic [1:0] ce_n_in,
  input wire logic [15:0] exp_addr_in,
  output logic [7:0] byte_rdata_out,
  output logic [7:0] exp_rdata_out
);
  logic [7:0] ram [0:255];
  logic [7:0] last_ff;
  always @(posedge ref_clk_in) begin
    last_ff <= byte_rdata_out;
    if (!(&ce_n_in) && !rw_n_in) begin
      ram[addr_in[7:0]] <= wdata_in;
    end
  end
  assign byte_rdata_out = (&ce_n_in) ? ~last_ff : ram[addr_in[7:0]];
  assign exp_rdata_out = exp_addr_in[7:0] ^ 8'h5a;
endmodule // scrmm_mem_model
`default_nettype wire

// ==== tb/scratchpad_and_memory_map_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----
// bench
// ----
module scratchpad_and_memory_map_tb;
  logic ref_clk_in = 0;
  logic sys_rst_in, ext_variant_in, main_power_ok_in, reg_wr_in, reg_rd_in, reg_indirect_in;
  logic reg_bit_in, wr_bank_reg_in, rd_bank_reg_in, push_in, pop_in;
  logic mem_req_in, mem_fetch_in, mem_wr_in, byte_rw_n_out, byte_ce0_n_out, byte_ce1_n_out;
  logic byte_supply_on_out, exp_req_out, exp_wr_out, exp_fetch_out, wr_blocked_out;
  logic [7:0] reg_addr_in, reg_wdata_in, push_data_in, mem_wdata_in, d, byte_rdata_in;
  logic [7:0] exp_rdata_in, reg_rdata_out, pop_data_out, stack_pointer_out, mem_rdata_out;
  logic [7:0] byte_wdata_out, exp_wdata_out;
  logic [2:0] bank_index_in;
  logic [15:0] mem_addr_in, exp_addr_out;
  logic [16:0] byte_addr_out;
  int fails = 0, comparisons = 0, cycles = 0;
  scrmm_top dut_u (.ref_clk_in, .sys_rst_in, .ext_variant_in, .main_power_ok_in, .reg_wr_in,
    .reg_rd_in, .reg_indirect_in, .reg_bit_in, .reg_addr_in, .reg_wdata_in, .wr_bank_reg_in,
    .rd_bank_reg_in, .bank_index_in, .push_in, .pop_in, .push_data_in, .mem_req_in,
    .mem_fetch_in, .mem_wr_in, .mem_addr_in, .mem_wdata_in, .byte_rdata_in, .exp_rdata_in,
    .reg_rdata_out, .pop_data_out, .stack_pointer_out, .mem_rdata_out, .byte_addr_out,
    .byte_wdata_out, .byte_rw_n_out, .byte_ce0_n_out, .byte_ce1_n_out, .byte_supply_on_out,
    .exp_req_out, .exp_wr_out, .exp_fetch_out, .exp_addr_out, .exp_wdata_out, .wr_blocked_out);
  scrmm_mem_model mdl_u (.ref_clk_in(ref_clk_in), .addr_in(byte_addr_out),
    .wdata_in(byte_wdata_out), .rw_n_in(byte_rw_n_out), .ce_n_in({byte_ce1_n_out,
    byte_ce0_n_out}), .exp_addr_in(exp_addr_out), .byte_rdata_out(byte_rdata_in),
    .exp_rdata_out(exp_rdata_in));
  initial begin
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  function automatic logic [7:0] loc(input int b, input logic [2:0] i);
    return {3'h0, 2'(b), i};
  endfunction
  task automatic cmp(input string n, input logic [16:0] e, input logic [16:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rw(input logic w, input logic i, input logic bt, input logic [7:0] a,
    input logic [7:0] v);
    reg_wr_in = w;
    reg_rd_in = !w;
    reg_indirect_in = i;
    reg_bit_in = bt;
    reg_addr_in = a;
    reg_wdata_in = v;
    @(negedge ref_clk_in);
    reg_wr_in = 0;
    reg_rd_in = 0;
  endtask
  task automatic mem(input logic f, input logic w, input logic [15:0] a);
    mem_req_in = 1;
    mem_fetch_in = f;
    mem_wr_in = w;
    mem_addr_in = a;
    mem_wdata_in = 8'($urandom);
    @(negedge ref_clk_in);
    mem_req_in = 0;
  endtask
  task automatic wrap_up;
    if (fails == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    {ext_variant_in, reg_wr_in, reg_rd_in, reg_indirect_in, reg_bit_in, wr_bank_reg_in} = 0;
    {rd_bank_reg_in, push_in, pop_in, mem_req_in, mem_fetch_in, mem_wr_in} = 0;
    {reg_addr_in, reg_wdata_in, push_data_in, mem_wdata_in, bank_index_in, mem_addr_in} = 0;
    main_power_ok_in = 1;
    sys_rst_in = 1;
    void'($urandom(32'h8975));
    repeat (5) @(negedge ref_clk_in);
    sys_rst_in = 0;
    cmp("sp", 8'h07, stack_pointer_out);
    rw(0, 0, 0, 8'hd0, 0);
    cmp("status", 8'h00, reg_rdata_out);
    ext_variant_in = 1;
    rw(1, 0, 0, 8'hd8, 8'h03);
    rw(0, 0, 0, 8'hd8, 0);
    cmp("size", 3'h3, reg_rdata_out[2:0]);
    ext_variant_in = 0;
    for (int i = 0; i < 6; i++) begin
      reg_addr_in = (i == 0) ? 8'h7f : 8'($urandom_range(127, 0));
      d = 8'($urandom);
      rw(1, 0, 0, reg_addr_in, d);
      rw(0, 0, 0, reg_addr_in, 0);
      cmp("scratch", d, reg_rdata_out);
    end
    for (int b = 0; b < 4; b++) begin
      rw(1, 0, 0, 8'hd0, 8'(b << 3));
      bank_index_in = 3'($urandom);
      d = 8'($urandom);
      reg_wdata_in = d;
      wr_bank_reg_in = 1;
      @(negedge ref_clk_in);
      wr_bank_reg_in = 0;
      rw(0, 0, 0, loc(b, bank_index_in), 0);
      cmp("bank", d, reg_rdata_out);
      rd_bank_reg_in = 1;
      @(negedge ref_clk_in);
      rd_bank_reg_in = 0;
      cmp("wreg", d, reg_rdata_out);
    end
    rw(1, 0, 0, 8'hd0, 8'h00);
    rw(1, 0, 0, 8'h2c, 8'h00);
    rw(1, 0, 1, 8'h65, 8'h01);
    rw(0, 0, 0, 8'h2c, 0);
    cmp("bits", 8'h20, reg_rdata_out);
    d = 8'($urandom);
    push_data_in = d;
    push_in = 1;
    @(negedge ref_clk_in);
    push_in = 0;
    cmp("sp", 8'h08, stack_pointer_out);
    rw(0, 0, 0, 8'h08, 0);
    cmp("stack", d, reg_rdata_out);
    pop_in = 1;
    @(negedge ref_clk_in);
    pop_in = 0;
    cmp("pop", d, pop_data_out);
    cmp("sp", 8'h07, stack_pointer_out);
    rw(1, 1, 0, 8'h81, 8'h55);
    rw(0, 0, 0, 8'h81, 0);
    cmp("sp", 8'h07, reg_rdata_out);
    rw(0, 1, 0, 8'h81, 0);
    cmp("indirect", 8'h00, reg_rdata_out);
    rw(1, 0, 0, 8'hc6, 8'h58);
    rw(0, 0, 0, 8'hc6, 0);
    cmp("mapctl", 8'h58, reg_rdata_out);
    ext_variant_in = 1;
    rw(1, 0, 0, 8'hd8, 8'h01);
    rw(0, 0, 0, 8'hd8, 0);
    cmp("size", 3'h3, reg_rdata_out[2:0]);
    ext_variant_in = 0;
    mem(0, 1, 16'h6000);
    cmp("ce0", 1'b0, byte_ce0_n_out);
    cmp("rw", 1'b0, byte_rw_n_out);
    mem(0, 1, 16'h1000);
    cmp("blocked", 1'b1, wr_blocked_out);
    mem(1, 0, 16'h1000);
    cmp("fetch", 2'b01, {byte_ce0_n_out, byte_rw_n_out});
    mem(1, 0, 16'h7000);
    cmp("exp", {1'b1, 16'h7000}, {exp_req_out, exp_addr_out});
    rw(1, 0, 0, 8'hc6, 8'h08);
    for (int i = 0; i < 4; i++) begin
      mem(0, 1, (i == 0) ? 16'h0000 : 16'($urandom_range(32767, 0)));
      cmp("ce0", 1'b0, byte_ce0_n_out);
    end
    main_power_ok_in = 0;
    repeat (2) @(negedge ref_clk_in);
    cmp("supply", 1'b0, byte_supply_on_out);
    wrap_up();
  end
endmodule // scratchpad_and_memory_map_tb
`default_nettype wire
